/* hw/mpwm_pkg.sv */
// Package of the motor PWM update and override block: register offsets,
// field positions, reset values and widths.
// Assumes a classic Wishbone slave with 32-bit data and 16-bit registers.
package mpwm_pkg;

	// Register byte offsets, one aligned word each
	localparam logic [7:0] MPWM_PIN_CONTROL_OFS    = 8'h00;
	localparam logic [7:0] MPWM_UPDATE_CONTROL_OFS = 8'h04;
	localparam logic [7:0] MPWM_DEAD_TIME_VAL_OFS  = 8'h08;
	localparam logic [7:0] MPWM_DEAD_TIME_SEL_OFS  = 8'h0C;
	localparam logic [7:0] MPWM_FAULT_A_OFS        = 8'h10;
	localparam logic [7:0] MPWM_OVERRIDE_OFS       = 8'h14;
	localparam logic [7:0] MPWM_DUTY_ONE_OFS       = 8'h18;
	localparam logic [7:0] MPWM_DUTY_TWO_OFS       = 8'h1C;
	localparam logic [7:0] MPWM_DUTY_THREE_OFS     = 8'h20;
	localparam logic [7:0] MPWM_STATUS_OFS         = 8'h24;

	// Pin control fields (per pair i: bit base + i)
	localparam int MPWM_PEN_L_LSB = 0;
	localparam int MPWM_PEN_H_LSB = 4;
	localparam int MPWM_PAIR_OUTPUT_STYLE_LSB  = 8;

	// Update control fields
	localparam int MPWM_UPDATE_DISABLE_BIT  = 0;
	localparam int MPWM_OVERRIDE_SYNC_BIT = 1;
	localparam int MPWM_IUE_BIT   = 2;
	localparam int MPWM_EVPS_LSB  = 8;

	// Dead-time value fields
	localparam int MPWM_DTA_LSB   = 0;
	localparam int MPWM_DEAD_TIME_PRESCALE_A_LSB = 6;
	localparam int MPWM_DTB_LSB   = 8;
	localparam int MPWM_DEAD_TIME_PRESCALE_B_LSB = 14;

	// Pair fields laid out two bits per pair: low pin or falling edge at 2i, high pin or rising edge at 2i+1
	localparam int MPWM_PAIR_LO_LSB = 0;
	localparam int MPWM_PAIR_HI_LSB = 8;

	// Fault A control
	localparam int MPWM_FAULT_A_PAIR_ENABLE_LSB   = 0;
	localparam int MPWM_FAULT_A_LATCH_MODE_BIT  = 7;

	// Status fields
	localparam int MPWM_ST_LATCH_BIT = 0;
	localparam int MPWM_ST_PIN_BIT   = 1;

	// Widths and pair count
	localparam int MPWM_REG_W   = 16;
	localparam int MPWM_DT_W    = 6;
	localparam int MPWM_DTCNT_W = 9;
	localparam int MPWM_MAX_PAIRS = 3;

	// Reset values
	localparam logic [15:0] MPWM_DUTY_RST = 16'h0000;

endpackage

/* hw/mpwm_update_override.sv */
// Motor PWM update, dead-time and output override logic with its registers.
// Assumes a time base outside this block that gives a count and a period
// tick on clk_i; fault and configuration pins arrive asynchronously.
// Operation
// RULE_01 - Enable bit hands pin to PWM
// RULE_02 - Pin enables reset from default setting
// RULE_03 - Immediate update bit picks duty timing
// RULE_04 - Override sync bit picks override timing
// RULE_05 - Update disable blocks buffer transfers
// RULE_06 - Dead time is count times prescaled period
// RULE_07 - Override enable one gives generator control
// RULE_08 - Override enable zero uses manual value
// RULE_09 - Manual value one active, zero inactive
// RULE_10 - Three sixteen-bit duty value registers
// RULE_11 - Small instance has first pair only
// RULE_12 - Complementary low is inverted high
// RULE_13 - Per-edge bits pick dead-time unit
// RULE_14 - Enabled fault forces programmed pair levels
//
// The register addresses and the Wishbone register port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module mpwm_update_override
	import mpwm_pkg::*;
#(
	parameter int NUM_PAIRS = 3
)
(
	// Clock and reset
	input  wire logic                 clk_i,
	input  wire logic                 rst_i,
	// Wishbone slave
	input  wire logic                 wb_cyc_i,
	input  wire logic                 wb_stb_i,
	input  wire logic                 wb_we_i,
	input  wire logic [7:0]           wb_adr_i,
	input  wire logic [3:0]           wb_sel_i,
	input  wire logic [31:0]          wb_dat_i,
	output logic                      wb_ack_o,
	output logic [31:0]               wb_dat_o,
	// Time base
	input  wire logic                 time_base_tick_i,
	input  wire logic [15:0]          time_base_count_i,
	// Pins and configuration
	input  wire logic                 fault_a_n_i,
	input  wire logic                 pwm_pin_default_setting_i,
	output logic [NUM_PAIRS-1:0]      pwm_high_o,
	output logic [NUM_PAIRS-1:0]      pwm_low_o,
	output logic [NUM_PAIRS-1:0]      high_pin_output_enable_o,
	output logic [NUM_PAIRS-1:0]      low_pin_output_enable_o,
	output logic                      period_load_o,
	output logic [3:0]                event_trigger_postscale_o
);

	localparam int NP = NUM_PAIRS;

	generate
		if (NP < 1 || NP > MPWM_MAX_PAIRS)
		begin : g_bad
			$error("NUM_PAIRS must be 1 to 3");
		end
	endgenerate

	// Synchronisers
	logic [1:0] fault_sync_ff;
	logic [1:0] dflt_sync_ff;

	// Register state
	logic                 wb_ack_ff;
	logic [31:0]          wb_dat_ff;
	logic [NP-1:0]        pair_output_style_ff;
	logic [NP-1:0]        pen_h_ff;
	logic [NP-1:0]        pen_l_ff;
	logic [NP-1:0]        nxt_pen_h;
	logic [NP-1:0]        nxt_pen_l;
	logic                 immediate_update_ff;
	logic                 override_sync_ff;
	logic                 update_disable_ff;
	logic [3:0]           evps_ff;
	logic [5:0]           dt_count_a_ff;
	logic [5:0]           dt_count_b_ff;
	logic [1:0]           dt_prescale_a_ff;
	logic [1:0]           dt_prescale_b_ff;
	logic [NP-1:0]        dt_rise_sel_ff;
	logic [NP-1:0]        dt_fall_sel_ff;
	logic [NP-1:0]        faov_h_ff;
	logic [NP-1:0]        faov_l_ff;
	logic [NP-1:0]        fault_a_pair_enable_ff;
	logic                 fault_a_latch_mode_ff;
	logic                 fault_latched_ff;
	logic [NP-1:0]        ovd_h_ff;
	logic [NP-1:0]        ovd_l_ff;
	logic [NP-1:0]        pout_h_ff;
	logic [NP-1:0]        pout_l_ff;
	logic [NP-1:0]        ovd_h_eff_ff;
	logic [NP-1:0]        ovd_l_eff_ff;
	logic [NP-1:0]        pout_h_eff_ff;
	logic [NP-1:0]        pout_l_eff_ff;
	logic [15:0]          duty_buf_ff [NP];
	logic [15:0]          duty_act_ff [NP];
	logic                 period_load_ff;

	// Bus decode, fault and dead-time delays
	logic        access;
	logic        wr;
	logic [15:0] wmask;
	logic [15:0] img;
	logic [15:0] merged;
	logic        fault_pin;
	logic        fault_now;
	logic [8:0]  delay_a;
	logic [8:0]  delay_b;

	assign access    = wb_cyc_i & wb_stb_i & ~wb_ack_ff;
	// Writes land at the edge where the master samples ack, not before
	assign wr        = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_ff;
	assign wmask     = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
	assign merged    = (img & ~wmask) | (wb_dat_i[15:0] & wmask);
	assign fault_pin = ~fault_sync_ff[1];
	// Latched mode holds the fault until software clears it
	assign fault_now = fault_pin | (~fault_a_latch_mode_ff & fault_latched_ff);
	// Count shifted by prescale: 1, 2, 4 or 8 clocks per step
	assign delay_a   = 9'(dt_count_a_ff) << dt_prescale_a_ff; // see RULE_06
	assign delay_b   = 9'(dt_count_b_ff) << dt_prescale_b_ff; // see RULE_06

	always_ff @(posedge clk_i)
	begin
		fault_sync_ff <= {fault_sync_ff[0], fault_a_n_i};
		dflt_sync_ff  <= {dflt_sync_ff[0], pwm_pin_default_setting_i};
	end

	// Read image of the addressed register; absent pairs read as zero
	always_comb
	begin
		img = 16'h0000;
		unique case (wb_adr_i)
			MPWM_PIN_CONTROL_OFS:
				for (int i = 0; i < NP; i++)
				begin
					img[MPWM_PEN_L_LSB + i] = pen_l_ff[i];
					img[MPWM_PEN_H_LSB + i] = pen_h_ff[i];
					img[MPWM_PAIR_OUTPUT_STYLE_LSB + i]  = pair_output_style_ff[i];
				end
			MPWM_UPDATE_CONTROL_OFS:
			begin
				img[MPWM_UPDATE_DISABLE_BIT]                = update_disable_ff;
				img[MPWM_OVERRIDE_SYNC_BIT]               = override_sync_ff;
				img[MPWM_IUE_BIT]                 = immediate_update_ff;
				img[MPWM_EVPS_LSB +: 4]           = evps_ff;
			end
			MPWM_DEAD_TIME_VAL_OFS:
				img = {dt_prescale_b_ff, dt_count_b_ff, dt_prescale_a_ff, dt_count_a_ff};
			MPWM_DEAD_TIME_SEL_OFS:
				for (int i = 0; i < NP; i++)
				begin
					img[MPWM_PAIR_LO_LSB + 2*i]     = dt_fall_sel_ff[i];
					img[MPWM_PAIR_LO_LSB + 2*i + 1] = dt_rise_sel_ff[i];
				end
			MPWM_FAULT_A_OFS:
			begin
				img[MPWM_FAULT_A_LATCH_MODE_BIT] = fault_a_latch_mode_ff;
				for (int i = 0; i < NP; i++)
				begin
					img[MPWM_FAULT_A_PAIR_ENABLE_LSB + i]          = fault_a_pair_enable_ff[i];
					img[MPWM_PAIR_HI_LSB + 2*i]     = faov_l_ff[i];
					img[MPWM_PAIR_HI_LSB + 2*i + 1] = faov_h_ff[i];
				end
			end
			MPWM_OVERRIDE_OFS:
				for (int i = 0; i < NP; i++)
				begin
					img[MPWM_PAIR_LO_LSB + 2*i]     = pout_l_ff[i];
					img[MPWM_PAIR_LO_LSB + 2*i + 1] = pout_h_ff[i];
					img[MPWM_PAIR_HI_LSB + 2*i]     = ovd_l_ff[i];
					img[MPWM_PAIR_HI_LSB + 2*i + 1] = ovd_h_ff[i];
				end
			MPWM_DUTY_ONE_OFS:
				img = duty_buf_ff[0];
			MPWM_DUTY_TWO_OFS:
				img = (NP > 1) ? duty_buf_ff[NP > 1 ? 1 : 0] : 16'h0000; // see RULE_11
			MPWM_DUTY_THREE_OFS:
				img = (NP > 2) ? duty_buf_ff[NP > 2 ? 2 : 0] : 16'h0000; // see RULE_11
			MPWM_STATUS_OFS:
			begin
				img[MPWM_ST_LATCH_BIT] = fault_latched_ff;
				img[MPWM_ST_PIN_BIT]   = fault_pin;
			end
			default:
				img = 16'h0000;
		endcase
	end

	// Bus answer: one cycle after the request, unmapped reads give zero
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			wb_ack_ff <= 1'b0;
			wb_dat_ff <= 32'h0000_0000;
		end
		else
		begin
			wb_ack_ff <= access;
			wb_dat_ff <= (access & ~wb_we_i) ? {16'h0000, img} : 32'h0000_0000;
		end
	end

	// Pin enables; the next value also gates the pin flops, so both change together
	always_comb
	begin
		nxt_pen_h = pen_h_ff;
		nxt_pen_l = pen_l_ff;
		if (rst_i)
		begin
			nxt_pen_h = {NP{dflt_sync_ff[1]}}; // see RULE_02
			nxt_pen_l = {NP{dflt_sync_ff[1]}}; // see RULE_02
		end
		else if (wr && wb_adr_i == MPWM_PIN_CONTROL_OFS)
			for (int i = 0; i < NP; i++)
			begin
				nxt_pen_l[i] = merged[MPWM_PEN_L_LSB + i];
				nxt_pen_h[i] = merged[MPWM_PEN_H_LSB + i];
			end
	end

	always_ff @(posedge clk_i)
	begin
		pen_h_ff <= nxt_pen_h;
		pen_l_ff <= nxt_pen_l;
		if (rst_i)
			pair_output_style_ff <= '0;
		else if (wr && wb_adr_i == MPWM_PIN_CONTROL_OFS)
			for (int i = 0; i < NP; i++)
				pair_output_style_ff[i] <= merged[MPWM_PAIR_OUTPUT_STYLE_LSB + i];
	end

	// Update, dead-time and fault configuration
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			update_disable_ff      <= 1'b0;
			override_sync_ff       <= 1'b0;
			immediate_update_ff    <= 1'b0;
			evps_ff                <= 4'h0;
			dt_count_a_ff          <= 6'h00;
			dt_count_b_ff          <= 6'h00;
			dt_prescale_a_ff       <= 2'h0;
			dt_prescale_b_ff       <= 2'h0;
			dt_rise_sel_ff         <= '0;
			dt_fall_sel_ff         <= '0;
			fault_a_pair_enable_ff <= '0;
			fault_a_latch_mode_ff  <= 1'b0;
			faov_h_ff              <= '0;
			faov_l_ff              <= '0;
		end
		else if (wr)
		begin
			if (wb_adr_i == MPWM_UPDATE_CONTROL_OFS)
			begin
				update_disable_ff   <= merged[MPWM_UPDATE_DISABLE_BIT];
				override_sync_ff    <= merged[MPWM_OVERRIDE_SYNC_BIT];
				immediate_update_ff <= merged[MPWM_IUE_BIT];
				evps_ff             <= merged[MPWM_EVPS_LSB +: 4];
			end
			if (wb_adr_i == MPWM_DEAD_TIME_VAL_OFS)
			begin
				dt_count_a_ff    <= merged[MPWM_DTA_LSB +: MPWM_DT_W];
				dt_prescale_a_ff <= merged[MPWM_DEAD_TIME_PRESCALE_A_LSB +: 2];
				dt_count_b_ff    <= merged[MPWM_DTB_LSB +: MPWM_DT_W];
				dt_prescale_b_ff <= merged[MPWM_DEAD_TIME_PRESCALE_B_LSB +: 2];
			end
			for (int i = 0; i < NP; i++)
			begin
				if (wb_adr_i == MPWM_DEAD_TIME_SEL_OFS)
				begin
					dt_fall_sel_ff[i] <= merged[MPWM_PAIR_LO_LSB + 2*i];
					dt_rise_sel_ff[i] <= merged[MPWM_PAIR_LO_LSB + 2*i + 1];
				end
				if (wb_adr_i == MPWM_FAULT_A_OFS)
				begin
					fault_a_pair_enable_ff[i] <= merged[MPWM_FAULT_A_PAIR_ENABLE_LSB + i];
					faov_l_ff[i]              <= merged[MPWM_PAIR_HI_LSB + 2*i];
					faov_h_ff[i]              <= merged[MPWM_PAIR_HI_LSB + 2*i + 1];
				end
			end
			if (wb_adr_i == MPWM_FAULT_A_OFS)
				fault_a_latch_mode_ff <= merged[MPWM_FAULT_A_LATCH_MODE_BIT];
		end
	end

	// Latched fault: a write to fault control clears it, a live fault wins
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			fault_latched_ff <= 1'b0;
		else if (fault_pin)
			fault_latched_ff <= 1'b1;
		else if (wr && wb_adr_i == MPWM_FAULT_A_OFS)
			fault_latched_ff <= 1'b0;
	end

	// Override: staged by software, made effective per the sync bit
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			ovd_h_ff      <= '1;
			ovd_l_ff      <= '1;
			pout_h_ff     <= '0;
			pout_l_ff     <= '0;
			ovd_h_eff_ff  <= '1;
			ovd_l_eff_ff  <= '1;
			pout_h_eff_ff <= '0;
			pout_l_eff_ff <= '0;
		end
		else
		begin
			if (wr && wb_adr_i == MPWM_OVERRIDE_OFS)
				for (int i = 0; i < NP; i++)
				begin
					pout_l_ff[i] <= merged[MPWM_PAIR_LO_LSB + 2*i];
					pout_h_ff[i] <= merged[MPWM_PAIR_LO_LSB + 2*i + 1];
					ovd_l_ff[i]  <= merged[MPWM_PAIR_HI_LSB + 2*i];
					ovd_h_ff[i]  <= merged[MPWM_PAIR_HI_LSB + 2*i + 1];
				end
			if (!override_sync_ff || time_base_tick_i) // see RULE_04
			begin
				ovd_h_eff_ff  <= ovd_h_ff;
				ovd_l_eff_ff  <= ovd_l_ff;
				pout_h_eff_ff <= pout_h_ff;
				pout_l_eff_ff <= pout_l_ff;
			end
		end
	end

	// Period buffer transfer strobe to the time base
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			period_load_ff <= 1'b0;
		else
			period_load_ff <= time_base_tick_i & ~update_disable_ff; // see RULE_05
	end

	genvar g;
	generate
		for (g = 0; g < NP; g++)
		begin : g_pair
			logic       raw;
			logic       prev_raw_ff;
			logic       gen_h_ff;
			logic       gen_l_ff;
			logic [8:0] dt_cnt_ff;
			logic [8:0] dly;
			logic       vh;
			logic       vl;
			logic       hi_ff;
			logic       lo_ff;
			logic       force_f;

			// Duty buffer and active copy
			always_ff @(posedge clk_i)
			begin
				if (rst_i)
				begin
					duty_buf_ff[g] <= MPWM_DUTY_RST;
					duty_act_ff[g] <= MPWM_DUTY_RST;
				end
				else
				begin
					if (wr && wb_adr_i == MPWM_DUTY_ONE_OFS + 8'(4*g)) // see RULE_10
						duty_buf_ff[g] <= merged;
					if (update_disable_ff) // see RULE_05
						duty_act_ff[g] <= duty_act_ff[g];
					else if (immediate_update_ff && wr
						&& wb_adr_i == MPWM_DUTY_ONE_OFS + 8'(4*g)) // see RULE_03
						duty_act_ff[g] <= merged;
					else if (time_base_tick_i) // see RULE_03
						duty_act_ff[g] <= duty_buf_ff[g];
				end
			end

			assign raw = time_base_count_i < duty_act_ff[g];
			// Rising edge of high uses the rise select, falling uses the fall select
			assign dly = (raw ? dt_rise_sel_ff[g] : dt_fall_sel_ff[g]) ? delay_b : delay_a; // see RULE_13

			// Both outputs held inactive while the dead time runs out
			always_ff @(posedge clk_i)
			begin
				if (rst_i)
				begin
					prev_raw_ff <= 1'b0;
					gen_h_ff    <= 1'b0;
					gen_l_ff    <= 1'b0;
					dt_cnt_ff   <= 9'h000;
				end
				else if (pair_output_style_ff[g])
				begin
					prev_raw_ff <= raw;
					gen_h_ff    <= raw;
					gen_l_ff    <= raw;
					dt_cnt_ff   <= 9'h000;
				end
				else if (raw != prev_raw_ff)
				begin
					prev_raw_ff <= raw;
					gen_h_ff    <= (dly == 9'h000) & raw;
					gen_l_ff    <= (dly == 9'h000) & ~raw; // see RULE_12
					dt_cnt_ff   <= dly; // see RULE_06
				end
				else if (dt_cnt_ff > 9'h001)
					dt_cnt_ff <= dt_cnt_ff - 9'h001;
				else
				begin
					dt_cnt_ff <= 9'h000;
					gen_h_ff  <= prev_raw_ff;
					gen_l_ff  <= ~prev_raw_ff; // see RULE_12
				end
			end

			assign force_f = fault_a_pair_enable_ff[g] & fault_now; // see RULE_14
			// Manual value 1 drives the active level, 0 the inactive one
			assign vh = force_f ? faov_h_ff[g]
				: (ovd_h_eff_ff[g] ? gen_h_ff : pout_h_eff_ff[g]); // see RULE_07
			assign vl = force_f ? faov_l_ff[g]
				: (ovd_l_eff_ff[g] ? gen_l_ff : pout_l_eff_ff[g]); // see RULE_08

			always_ff @(posedge clk_i)
			begin
				if (rst_i)
				begin
					hi_ff <= 1'b0;
					lo_ff <= 1'b0;
				end
				else
				begin
					hi_ff <= vh & nxt_pen_h[g]; // see RULE_09
					lo_ff <= vl & nxt_pen_l[g]; // see RULE_09
				end
			end

			// Disabled pins are released to general I/O and driven low here
			assign pwm_high_o[g] = hi_ff; // see RULE_01
			assign pwm_low_o[g]  = lo_ff; // see RULE_01
		end
	endgenerate

	assign wb_ack_o                  = wb_ack_ff;
	assign wb_dat_o                  = wb_dat_ff;
	assign high_pin_output_enable_o  = pen_h_ff; // see RULE_01
	assign low_pin_output_enable_o   = pen_l_ff; // see RULE_01
	assign period_load_o             = period_load_ff;
	assign event_trigger_postscale_o = evps_ff;

endmodule

`default_nettype wire

/* verification/mpwm_asserts.sv */
// Port-level checker of the motor PWM update and override block.
// Assumes one clock, clk_i, and a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none

module mpwm_asserts
	import mpwm_pkg::*;
#(
	parameter int NUM_PAIRS = 3
)
(
	// Clock and reset
	input wire logic                 clk_i,
	input wire logic                 rst_i,
	// Wishbone slave
	input wire logic                 wb_cyc_i,
	input wire logic                 wb_stb_i,
	input wire logic                 wb_we_i,
	input wire logic [7:0]           wb_adr_i,
	input wire logic [3:0]           wb_sel_i,
	input wire logic [31:0]          wb_dat_i,
	input wire logic                 wb_ack_o,
	input wire logic [31:0]          wb_dat_o,
	// Time base and pins
	input wire logic                 time_base_tick_i,
	input wire logic [15:0]          time_base_count_i,
	input wire logic                 fault_a_n_i,
	input wire logic                 pwm_pin_default_setting_i,
	input wire logic [NUM_PAIRS-1:0] pwm_high_o,
	input wire logic [NUM_PAIRS-1:0] pwm_low_o,
	input wire logic [NUM_PAIRS-1:0] high_pin_output_enable_o,
	input wire logic [NUM_PAIRS-1:0] low_pin_output_enable_o,
	input wire logic                 period_load_o,
	input wire logic [3:0]           event_trigger_postscale_o
);
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	ack_latency_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("ack missing one cycle after request");
	ack_single_a: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held longer than one cycle");
	ack_cause_a: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i) && $past(wb_stb_i))
		else $error("ack without a request");
	read_upper_a: assert property (wb_ack_o |-> wb_dat_o[31:16] == 16'h0000)
		else $error("upper read data not zero");
	write_zero_a: assert property (wb_ack_o && $past(wb_we_i) |-> wb_dat_o == 32'h0000_0000)
		else $error("read data not zero on write");
	unmapped_zero_a: assert property (wb_ack_o && !$past(wb_we_i)
		&& ($past(wb_adr_i) > MPWM_STATUS_OFS) |-> wb_dat_o == 32'h0000_0000)
		else $error("unmapped read not zero");
	period_load_a: assert property (period_load_o |-> $past(time_base_tick_i))
		else $error("period load without tick");
	high_enable_a: assert property ((pwm_high_o & ~high_pin_output_enable_o) == '0)
		else $error("disabled high pin driven");
	low_enable_a: assert property ((pwm_low_o & ~low_pin_output_enable_o) == '0)
		else $error("disabled low pin driven");
	reset_default_a: assert property ($fell(rst_i) |->
		high_pin_output_enable_o == {NUM_PAIRS{pwm_pin_default_setting_i}}
		&& low_pin_output_enable_o == {NUM_PAIRS{pwm_pin_default_setting_i}})
		else $error("pin enables not from default setting");
endmodule

bind mpwm_update_override mpwm_asserts #(.NUM_PAIRS(NUM_PAIRS)) mpwm_asserts_i (
	.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
	.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
	.wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .time_base_tick_i(time_base_tick_i),
	.time_base_count_i(time_base_count_i), .fault_a_n_i(fault_a_n_i),
	.pwm_pin_default_setting_i(pwm_pin_default_setting_i), .pwm_high_o(pwm_high_o),
	.pwm_low_o(pwm_low_o), .high_pin_output_enable_o(high_pin_output_enable_o),
	.low_pin_output_enable_o(low_pin_output_enable_o), .period_load_o(period_load_o),
	.event_trigger_postscale_o(event_trigger_postscale_o));

`default_nettype wire

/* verification/mpwm_gate_model.sv */
// Behavioural gate driver stage on the pin side of the PWM block.
// Assumes pin levels are 1 for active; counts cycles with both switches on.
`timescale 1ns/1ps
`default_nettype none

module mpwm_gate_model
#(
	parameter int NUM_PAIRS = 3
)
(
	// Clock and reset
	input  wire logic                 clk_i,
	input  wire logic                 rst_i,
	// Gate inputs
	input  wire logic [NUM_PAIRS-1:0] high_i,
	input  wire logic [NUM_PAIRS-1:0] low_i,
	// Shoot-through tally
	output logic [15:0]               overlap_count_o
);
	// Both switches of a leg on at once would short the supply
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			overlap_count_o <= 16'h0000;
		else if ((high_i & low_i) != '0)
			overlap_count_o <= overlap_count_o + 16'h0001;
	end
endmodule

`default_nettype wire

/* verification/motor_pwm_update_override_bench.sv */
// Self-checking bench of the motor PWM update and override block.
// Assumes the checker is bound to the design and a 20 MHz clock.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin mismatches++; \
	$display("[FAIL] %0t got %0h exp %0h", $time, (a), (b)); end end

module motor_pwm_update_override_bench;
	import mpwm_pkg::*;
	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic        cyc = 1'b0;
	logic        we = 1'b0;
	logic [7:0]  adr = 8'h00;
	logic [31:0] wdat = 32'h0;
	logic [31:0] rdat;
	logic        ack;
	logic        tick = 1'b0;
	logic [15:0] count = 16'h0010;
	logic        fault_n = 1'b1;
	logic [2:0]  ph, pl, eh, el;
	logic        pload;
	logic [3:0]  evps;
	logic [15:0] overlaps;
	logic [31:0] rd;
	logic        ack1;
	logic [31:0] rdat1;
	logic [31:0] rd1;
	logic        ph1, pl1, eh1, el1;
	int          loads = 0;
	int          mismatches = 0;
	int          tests_run = 0;

	mpwm_update_override #(.NUM_PAIRS(3)) mpwm_update_override_i (
		.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(4'h3), .wb_dat_i(wdat), .wb_ack_o(ack), .wb_dat_o(rdat),
		.time_base_tick_i(tick), .time_base_count_i(count), .fault_a_n_i(fault_n),
		.pwm_pin_default_setting_i(1'b1), .pwm_high_o(ph), .pwm_low_o(pl),
		.high_pin_output_enable_o(eh), .low_pin_output_enable_o(el),
		.period_load_o(pload), .event_trigger_postscale_o(evps));

	// Small instance with one pair, driven by the same bus and time base
	mpwm_update_override #(.NUM_PAIRS(1)) mpwm_update_override_one_i (
		.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(4'h3), .wb_dat_i(wdat), .wb_ack_o(ack1), .wb_dat_o(rdat1),
		.time_base_tick_i(tick), .time_base_count_i(count), .fault_a_n_i(fault_n),
		.pwm_pin_default_setting_i(1'b1), .pwm_high_o(ph1), .pwm_low_o(pl1),
		.high_pin_output_enable_o(eh1), .low_pin_output_enable_o(el1),
		.period_load_o(), .event_trigger_postscale_o());

	mpwm_gate_model #(.NUM_PAIRS(3)) mpwm_gate_model_i (
		.clk_i(clk_i), .rst_i(rst_i), .high_i(ph), .low_i(pl), .overlap_count_o(overlaps));

	initial
	begin
		forever #25 clk_i = ~clk_i;
	end

	always @(posedge clk_i)
		if (pload === 1'b1)
			loads <= loads + 1;

	task automatic xfer(input logic w, input logic [7:0] a, input logic [15:0] d);
		@(posedge clk_i);
		cyc <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= {16'h0000, d};
		do
			@(posedge clk_i);
		while (ack !== 1'b1);
		rd = rdat;
		rd1 = ack1 ? rdat1 : 32'hFFFF_FFFF;
		cyc <= 1'b0;
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [15:0] e);
		xfer(1'b0, a, 16'h0000);
		`CHK(rd, {16'h0000, e})
	endtask

	task automatic pins(input logic h, input logic l);
		repeat (4) @(posedge clk_i);
		`CHK({ph[0], pl[0]}, {h, l})
		`CHK({ph1, pl1}, {h, l})
	endtask

	task automatic pulse_tick();
		@(posedge clk_i);
		tick <= 1'b1;
		@(posedge clk_i);
		tick <= 1'b0;
	endtask

	task automatic summarize();
		if (mismatches == 0 && tests_run > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	initial
	begin
		repeat (20000) @(posedge clk_i);
		mismatches++;
		summarize();
	end

	initial
	begin
		repeat (8) @(posedge clk_i);
		rst_i <= 1'b0;
		rd_chk(MPWM_PIN_CONTROL_OFS, 16'h0077);
		`CHK({eh1, el1}, 2'b11)
		rd_chk(MPWM_OVERRIDE_OFS, 16'h3F00);
		`CHK(rd1, 32'h0000_0300)
		rd_chk(MPWM_DUTY_ONE_OFS, MPWM_DUTY_RST);
		rd_chk(8'h3C, 16'h0000);
		xfer(1'b1, MPWM_PIN_CONTROL_OFS, 16'h0000);
		pins(1'b0, 1'b0);
		`CHK({eh, el}, 6'h00)
		xfer(1'b1, MPWM_PIN_CONTROL_OFS, 16'h0077);
		// Immediate update, then generator drives a complementary pair
		xfer(1'b1, MPWM_UPDATE_CONTROL_OFS, 16'h0004);
		xfer(1'b1, MPWM_DUTY_ONE_OFS, 16'h0100);
		pins(1'b1, 1'b0);
		count <= 16'h0200;
		pins(1'b0, 1'b1);
		count <= 16'h0010;
		pins(1'b1, 1'b0);
		`CHK(overlaps, 16'h0000)
		// Buffered update waits for the period tick
		xfer(1'b1, MPWM_UPDATE_CONTROL_OFS, 16'h0000);
		xfer(1'b1, MPWM_DUTY_ONE_OFS, 16'h0008);
		pins(1'b1, 1'b0);
		pulse_tick();
		pins(1'b0, 1'b1);
		// Transfers blocked while update disable is set
		xfer(1'b1, MPWM_UPDATE_CONTROL_OFS, 16'h0001);
		xfer(1'b1, MPWM_DUTY_ONE_OFS, 16'h0100);
		pulse_tick();
		pins(1'b0, 1'b1);
		xfer(1'b1, MPWM_UPDATE_CONTROL_OFS, 16'h0000);
		pulse_tick();
		pins(1'b1, 1'b0);
		for (int i = 0; i < 3; i++)
		begin
			xfer(1'b1, MPWM_DUTY_ONE_OFS + 8'(4 * i), 16'hA5C3 ^ 16'(i));
			rd_chk(MPWM_DUTY_ONE_OFS + 8'(4 * i), 16'hA5C3 ^ 16'(i));
		end
		xfer(1'b0, MPWM_DUTY_TWO_OFS, 16'h0000);
		`CHK(rd1, 32'h0000_0000)
		// Manual override of pair 0, applied on the next cycle
		xfer(1'b1, MPWM_OVERRIDE_OFS, 16'h3C01);
		pins(1'b0, 1'b1);
		xfer(1'b1, MPWM_OVERRIDE_OFS, 16'h3C03);
		pins(1'b1, 1'b1);
		xfer(1'b1, MPWM_OVERRIDE_OFS, 16'h3C00);
		pins(1'b0, 1'b0);
		// Synchronised override waits for the tick
		xfer(1'b1, MPWM_UPDATE_CONTROL_OFS, 16'h0A02);
		xfer(1'b1, MPWM_OVERRIDE_OFS, 16'h3C03);
		pins(1'b0, 1'b0);
		`CHK(evps, 4'hA)
		pulse_tick();
		pins(1'b1, 1'b1);
		xfer(1'b1, MPWM_OVERRIDE_OFS, 16'h3F00);
		pulse_tick();
		pins(1'b1, 1'b0);
		// Cycle-by-cycle fault forces pair 0 to high off, low on
		xfer(1'b1, MPWM_FAULT_A_OFS, 16'h0181);
		fault_n <= 1'b0;
		pins(1'b0, 1'b1);
		fault_n <= 1'b1;
		pins(1'b1, 1'b0);
		// Latched fault holds until software rewrites fault control
		xfer(1'b1, MPWM_FAULT_A_OFS, 16'h0101);
		fault_n <= 1'b0;
		pins(1'b0, 1'b1);
		fault_n <= 1'b1;
		pins(1'b0, 1'b1);
		rd_chk(MPWM_STATUS_OFS, 16'h0001);
		xfer(1'b1, MPWM_FAULT_A_OFS, 16'h0101);
		pins(1'b1, 1'b0);
		// Falling edge uses unit A (4 clocks), rising edge unit B (2 << 2 clocks)
		xfer(1'b1, MPWM_DEAD_TIME_VAL_OFS, 16'h8204);
		xfer(1'b1, MPWM_DEAD_TIME_SEL_OFS, 16'h0002);
		count <= 16'hF000;
		pins(1'b0, 1'b0);
		pins(1'b0, 1'b1);
		count <= 16'h0010;
		pins(1'b0, 1'b0);
		pins(1'b0, 1'b0);
		pins(1'b1, 1'b0);
		// Four ticks arrived with update disable clear, one with it set
		`CHK(loads, 4)
		summarize();
	end
endmodule

`undef CHK
`default_nettype wire
